// File: common/ua_consts.svh
// Purpose: Offsets, field positions, reset values for the serial port front end
// Assumes: 13-bit byte address on the register bus
// Notes: Definitions only
`ifndef UA_CONSTS_SVH
`define UA_CONSTS_SVH
`define UA_ADDR_W 13
`define UA_OFF_DATA 13'h1000
`define UA_OFF_IEN 13'h1004
`define UA_OFF_IID 13'h1008
`define UA_OFF_LCTL 13'h100c
`define UA_OFF_MCTL 13'h1010
`define UA_OFF_LSTS 13'h1014
`define UA_OFF_MSTS 13'h1018
`define UA_OFF_SCR 13'h101c
`define UA_LCR_BANK 7
`define UA_THR_RESET 8'hff
`define UA_DLL_RESET 8'h00
`define UA_DLM_RESET 8'h00
`define UA_IID_LS 3'h3
`define UA_IID_RD 3'h2
`define UA_IID_TE 3'h1
`define UA_IID_MS 3'h0
`define UA_RESP_OKAY 2'h0
`define UA_RESP_SLVERR 2'h2
`define UA_RX_FIFO_DEPTH 8
`define UA_TRIG_0 8'h01
`define UA_TRIG_1 8'h04
`define UA_TRIG_2 8'h08
`define UA_TRIG_3 8'h0e
`endif

// File: common/ua_pkg.sv
// Purpose: Types for the serial port front end
// Assumes: Constants live in ua_consts.svh
// Notes: Bus carriers and the block state record
package ua_pkg;
    typedef enum logic [4:0] {
        UA_IDLE = 5'h01,
        UA_W_ACC = 5'h02,
        UA_W_RESP = 5'h04,
        UA_R_ACC = 5'h08,
        UA_R_RESP = 5'h10
    } ua_bus_state_t;

    typedef struct packed {
        logic [12:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [12:0] araddr;
        logic arvalid;
        logic rready;
    } ua_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } ua_axi_rsp_t;

    typedef struct packed {
        ua_bus_state_t bus;
        ua_axi_rsp_t rsp;
        logic [7:0] transmit_holding;
        logic thr_full;
        logic [3:0] interrupt_enable;
        logic [7:0] fifo_control;
        logic [7:0] line_control;
        logic [4:0] modem_control;
        logic [7:0] scratch_pad;
        logic [7:0] dll;
        logic [7:0] divisor_high_byte;
        logic [3:0] line_err;
        logic [3:0] msr_delta;
        logic [3:0] msync1;
        logic [3:0] msync2;
        logic [3:0] mprev;
        logic irq;
        logic ddis;
        logic dtr_n;
        logic rts_n;
        logic out1_n;
        logic out2_n;
        logic dma_rx_n;
        logic dma_tx_n;
        logic [15:0] divisor;
    } ua_state_t;
endpackage

// File: src/ua_front_end.sv
// Purpose: Register front end, modem pins and receive buffer of a serial port
// Assumes: Host writes present address and data together
// Notes: Framing and baud generation sit outside this block
`include "ua_consts.svh"

module ua_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
)
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int PW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH+1);
    typedef struct packed {
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [LW-1:0] cnt;
        logic not_full;
    } ua_fifo_state_t;
    ua_fifo_state_t st;
    ua_fifo_state_t n;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    // Ready is a stored flag so the filling side sees a clean level
    assign in_ready = st.not_full;
    assign out_valid = st.cnt != '0;
    assign out_data = mem[st.rp];
    assign level = st.cnt;
    assign push = in_valid && st.not_full && !flush;
    assign pop = out_ready && out_valid && !flush;

    always_comb
    begin
        n = st;
        if (flush)
        begin
            n = '0;
        end
        else
        begin
            if (push)
            begin
                n.wp = PW'(st.wp + 1'b1);
            end
            if (pop)
            begin
                n.rp = PW'(st.rp + 1'b1);
            end
            n.cnt = LW'(st.cnt + LW'(push) - LW'(pop));
        end
        n.not_full = n.cnt != LW'(DEPTH);
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            st <= '0;
            st.not_full <= 1'b1;
        end
        else
        begin
            st <= n;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            mem[st.wp] <= in_data;
        end
    end
endmodule

module ua_front_end
    import ua_pkg::*;
#(
    parameter int FIFO_DEPTH = `UA_RX_FIFO_DEPTH
)
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire ua_axi_req_t axi_req,
    output ua_axi_rsp_t axi_rsp,
    input wire logic [7:0] rx_char_data,
    input wire logic rx_char_valid,
    output logic rx_char_ready,
    input wire logic [3:0] rx_line_err,
    output logic [7:0] tx_char_data,
    output logic tx_char_valid,
    input wire logic tx_char_ready,
    input wire logic clear_to_send_n,
    input wire logic data_set_ready_n,
    input wire logic ring_indicate_n,
    input wire logic carrier_detect_n,
    output logic terminal_ready_n,
    output logic request_to_send_n,
    output logic user_output_a_low,
    output logic user_output_b_low,
    output logic driver_disable,
    output logic dma_rx_ready_n,
    output logic dma_tx_ready_n,
    output logic interrupt_out,
    output logic [15:0] baud_divisor
);
    localparam int LW = $clog2(FIFO_DEPTH+1);
    ua_state_t st;
    ua_state_t n;
    logic rx_pop;
    logic rx_flush;
    logic rx_valid;
    logic [7:0] rx_head;
    logic [LW-1:0] rx_level;
    logic [7:0] lvl8;
    logic [7:0] trig;
    logic bank;
    logic [3:0] mchg;
    logic ls_p;
    logic rd_p;
    logic te_p;
    logic ms_p;
    logic [2:0] iid;
    logic [7:0] interrupt_identification;
    logic [7:0] line_status;
    logic [7:0] modem_status;
    logic [12:0] waddr;
    logic [12:0] raddr;
    logic [31:0] wd;

    ua_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) rx_buf (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .flush(rx_flush),
        .in_valid(rx_char_valid),
        .in_ready(rx_char_ready),
        .in_data(rx_char_data),
        .out_valid(rx_valid),
        .out_ready(rx_pop),
        .out_data(rx_head),
        .level(rx_level)
    );

    assign bank = st.line_control[`UA_LCR_BANK];
    assign waddr = axi_req.awaddr;
    assign raddr = axi_req.araddr;
    assign wd = axi_req.wdata;
    assign lvl8 = 8'(rx_level);
    assign mchg = st.msync2 ^ st.mprev;

    // Line status: data ready, sticky errors, holding empty
    assign line_status = {st.fifo_control[0] & (|st.line_err), ~st.thr_full, ~st.thr_full, st.line_err, rx_valid};
    assign modem_status = {~st.msync2, st.msr_delta};

    assign ls_p = st.interrupt_enable[2] && (|st.line_err);
    assign rd_p = st.interrupt_enable[0] && rx_valid;
    assign te_p = st.interrupt_enable[1] && !st.thr_full;
    assign ms_p = st.interrupt_enable[3] && (|st.msr_delta);

    always_comb
    begin
        if (ls_p)
        begin
            iid = `UA_IID_LS;
        end
        else if (rd_p)
        begin
            iid = `UA_IID_RD;
        end
        else if (te_p)
        begin
            iid = `UA_IID_TE;
        end
        else
        begin
            iid = `UA_IID_MS;
        end
        interrupt_identification = {{2{st.fifo_control[0]}}, 2'b00, iid, ~(ls_p | rd_p | te_p | ms_p)};
        case (st.fifo_control[7:6])
            2'b00: trig = `UA_TRIG_0;
            2'b01: trig = `UA_TRIG_1;
            2'b10: trig = `UA_TRIG_2;
            default: trig = `UA_TRIG_3;
        endcase
    end

    always_comb
    begin
        n = st;
        rx_pop = 1'b0;
        rx_flush = 1'b0;
        // Sync stage one feeds only stage two
        n.msync1 = {carrier_detect_n, ring_indicate_n, data_set_ready_n, clear_to_send_n};
        n.msync2 = st.msync1;
        n.mprev = st.msync2;
        if (st.thr_full && tx_char_ready)
        begin
            n.thr_full = 1'b0;
        end
        case (st.bus)
            UA_IDLE:
            begin
                if (axi_req.awvalid && axi_req.wvalid)
                begin
                    n.bus = UA_W_ACC;
                    n.rsp.awready = 1'b1;
                    n.rsp.wready = 1'b1;
                end
                else if (axi_req.arvalid)
                begin
                    n.bus = UA_R_ACC;
                    n.rsp.arready = 1'b1;
                    if (raddr == `UA_OFF_DATA && !bank)
                    begin
                        n.ddis = 1'b0;
                    end
                end
            end
            UA_W_ACC:
            begin
                n.rsp.awready = 1'b0;
                n.rsp.wready = 1'b0;
                n.rsp.bvalid = 1'b1;
                n.rsp.bresp = `UA_RESP_OKAY;
                n.bus = UA_W_RESP;
                if (waddr == `UA_OFF_DATA)
                begin
                    if (bank)
                    begin
                        n.dll = wd[7:0];
                    end
                    else
                    begin
                        n.transmit_holding = wd[7:0];
                        n.thr_full = 1'b1;
                    end
                end
                else if (waddr == `UA_OFF_IEN)
                begin
                    if (bank)
                    begin
                        n.divisor_high_byte = wd[7:0];
                    end
                    else
                    begin
                        n.interrupt_enable = wd[3:0];
                    end
                end
                else if (waddr == `UA_OFF_IID)
                begin
                    n.fifo_control = {wd[7:6], 2'b00, wd[3], 2'b00, wd[0]};
                    rx_flush = wd[1];
                    if (wd[2])
                    begin
                        n.thr_full = 1'b0;
                    end
                end
                else if (waddr == `UA_OFF_LCTL)
                begin
                    n.line_control = wd[7:0];
                end
                else if (waddr == `UA_OFF_MCTL)
                begin
                    n.modem_control = wd[4:0];
                end
                else if (waddr == `UA_OFF_SCR)
                begin
                    n.scratch_pad = wd[7:0];
                end
                else if (waddr != `UA_OFF_LSTS && waddr != `UA_OFF_MSTS)
                begin
                    n.rsp.bresp = `UA_RESP_SLVERR;
                end
            end
            UA_W_RESP:
            begin
                if (axi_req.bready)
                begin
                    n.rsp.bvalid = 1'b0;
                    n.bus = UA_IDLE;
                end
            end
            UA_R_ACC:
            begin
                n.rsp.arready = 1'b0;
                n.rsp.rvalid = 1'b1;
                n.rsp.rresp = `UA_RESP_OKAY;
                n.rsp.rdata = '0;
                n.bus = UA_R_RESP;
                if (raddr == `UA_OFF_DATA)
                begin
                    if (bank)
                    begin
                        n.rsp.rdata[7:0] = st.dll;
                    end
                    else
                    begin
                        n.rsp.rdata[7:0] = rx_valid ? rx_head : 8'h00;
                        rx_pop = rx_valid;
                    end
                end
                else if (raddr == `UA_OFF_IEN)
                begin
                    n.rsp.rdata[7:0] = bank ? st.divisor_high_byte : {4'h0, st.interrupt_enable};
                end
                else if (raddr == `UA_OFF_IID)
                begin
                    n.rsp.rdata[7:0] = bank ? st.fifo_control : interrupt_identification;
                end
                else if (raddr == `UA_OFF_LCTL)
                begin
                    n.rsp.rdata[7:0] = st.line_control;
                end
                else if (raddr == `UA_OFF_MCTL)
                begin
                    n.rsp.rdata[7:0] = {3'h0, st.modem_control};
                end
                else if (raddr == `UA_OFF_LSTS)
                begin
                    n.rsp.rdata[7:0] = line_status;
                    n.line_err = 4'h0;
                end
                else if (raddr == `UA_OFF_MSTS)
                begin
                    n.rsp.rdata[7:0] = modem_status;
                    n.msr_delta = 4'h0;
                end
                else if (raddr == `UA_OFF_SCR)
                begin
                    n.rsp.rdata[7:0] = st.scratch_pad;
                end
                else
                begin
                    n.rsp.rresp = `UA_RESP_SLVERR;
                end
            end
            UA_R_RESP:
            begin
                if (axi_req.rready)
                begin
                    n.rsp.rvalid = 1'b0;
                    n.ddis = 1'b1;
                    n.bus = UA_IDLE;
                end
            end
            default:
            begin
                n.bus = UA_IDLE;
            end
        endcase
        // New events win over a read-clear in the same cycle
        n.line_err = n.line_err | rx_line_err;
        n.msr_delta = n.msr_delta | {mchg[3], mchg[2] & st.msync2[2], mchg[1], mchg[0]};
        n.dtr_n = ~n.modem_control[0];
        n.rts_n = ~n.modem_control[1];
        n.out1_n = ~n.modem_control[2];
        n.out2_n = ~n.modem_control[3];
        n.divisor = {n.divisor_high_byte, n.dll};
        n.irq = ls_p | rd_p | te_p | ms_p;
        n.dma_tx_n = n.thr_full;
        // Mode 1 holds receive-ready low until the buffer drains
        if (!st.fifo_control[3] || !st.fifo_control[0])
        begin
            n.dma_rx_n = !rx_valid;
        end
        else if (lvl8 >= trig || lvl8 == 8'(FIFO_DEPTH))
        begin
            n.dma_rx_n = 1'b0;
        end
        else if (!rx_valid)
        begin
            n.dma_rx_n = 1'b1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            st <= '0;
            st.bus <= UA_IDLE;
            st.transmit_holding <= `UA_THR_RESET;
            st.dll <= `UA_DLL_RESET;
            st.divisor_high_byte <= `UA_DLM_RESET;
            st.msync1 <= 4'hf;
            st.msync2 <= 4'hf;
            st.mprev <= 4'hf;
            st.ddis <= 1'b1;
            st.dtr_n <= 1'b1;
            st.rts_n <= 1'b1;
            st.out1_n <= 1'b1;
            st.out2_n <= 1'b1;
            st.dma_rx_n <= 1'b1;
            st.dma_tx_n <= 1'b0;
        end
        else
        begin
            st <= n;
        end
    end

    assign axi_rsp = st.rsp;
    assign tx_char_data = st.transmit_holding;
    assign tx_char_valid = st.thr_full;
    assign terminal_ready_n = st.dtr_n;
    assign request_to_send_n = st.rts_n;
    assign user_output_a_low = st.out1_n;
    assign user_output_b_low = st.out2_n;
    assign driver_disable = st.ddis;
    assign dma_rx_ready_n = st.dma_rx_n;
    assign dma_tx_ready_n = st.dma_tx_n;
    assign interrupt_out = st.irq;
    assign baud_divisor = st.divisor;
endmodule

// File: test/ua_front_end_asserts.sv
// Purpose: Port-level checks for the serial port front end
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to every instance of the top module
`include "ua_consts.svh"

module ua_front_end_chk
    import ua_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
)
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire ua_axi_req_t axi_req,
    input wire ua_axi_rsp_t axi_rsp,
    input wire logic tx_char_valid,
    input wire logic tx_char_ready,
    input wire logic terminal_ready_n,
    input wire logic request_to_send_n,
    input wire logic user_output_a_low,
    input wire logic user_output_b_low,
    input wire logic driver_disable,
    input wire logic dma_rx_ready_n,
    input wire logic dma_tx_ready_n,
    input wire logic interrupt_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_wr_taken;
        axi_rsp.awready && axi_rsp.wready;
    endsequence

    sequence s_wr_answer;
        axi_rsp.bvalid && !axi_rsp.awready;
    endsequence

    a_reset_pins: assert property (
        $rose(rst_b) |-> terminal_ready_n && request_to_send_n && user_output_a_low
        && user_output_b_low) else $error("Modem or user pin wrong after reset");
    a_reset_misc: assert property (
        $rose(rst_b) |-> driver_disable && dma_rx_ready_n && !dma_tx_ready_n && !interrupt_out)
        else $error("Disable, dma or interrupt pin wrong after reset");
    a_write_pair: assert property (
        axi_rsp.awready || axi_rsp.wready |-> s_wr_taken
        and $past(axi_req.awvalid && axi_req.wvalid)) else $error("Write ready unpaired");
    a_write_answer: assert property (s_wr_taken |=> s_wr_answer)
        else $error("Write response late");
    a_bvalid_hold: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid)
        else $error("Write response dropped early");
    a_read_answer: assert property (axi_rsp.arready |=> axi_rsp.rvalid && !axi_rsp.arready)
        else $error("Read data late");
    a_rdata_hold: assert property (
        axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
        else $error("Read data not held");
    a_reserved_zero: assert property (axi_rsp.rvalid |-> axi_rsp.rdata[31:8] == 24'h0)
        else $error("Reserved read bits set");
    a_slverr_zero: assert property (
        axi_rsp.rvalid && axi_rsp.rresp == `UA_RESP_SLVERR |-> axi_rsp.rdata == 32'h0)
        else $error("Error read returned data");
    a_ddis_read: assert property (!driver_disable |-> axi_rsp.arready || axi_rsp.rvalid)
        else $error("Driver disable low outside a read");
    a_tx_load: assert property ($rose(tx_char_valid) |-> $past(axi_rsp.awready))
        else $error("Holding filled without a write");
    a_tx_drop: assert property (
        tx_char_valid && tx_char_ready && !axi_rsp.awready |=> !tx_char_valid)
        else $error("Holding not emptied after handshake");
endmodule

bind ua_front_end ua_front_end_chk #(.FIFO_DEPTH(FIFO_DEPTH)) i_chk (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .axi_req(axi_req),
    .axi_rsp(axi_rsp),
    .tx_char_valid(tx_char_valid),
    .tx_char_ready(tx_char_ready),
    .terminal_ready_n(terminal_ready_n),
    .request_to_send_n(request_to_send_n),
    .user_output_a_low(user_output_a_low),
    .user_output_b_low(user_output_b_low),
    .driver_disable(driver_disable),
    .dma_rx_ready_n(dma_rx_ready_n),
    .dma_tx_ready_n(dma_tx_ready_n),
    .interrupt_out(interrupt_out)
);

// File: test/ua_host_model.sv
// Purpose: Host side of the register bus, one transfer at a time
// Assumes: Requests change 1 ns after a clock edge
// Notes: A stuck write handshake returns response 2'h3
module ua_host_model
    import ua_pkg::*;
(
    input wire logic core_clk,
    output ua_axi_req_t axi_req,
    input wire ua_axi_rsp_t axi_rsp
);
    timeunit 1ns;
    timeprecision 1ps;
    initial axi_req = '0;

    task automatic wr(input logic [12:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge core_clk);
        #1;
        axi_req.awaddr = a;
        axi_req.wdata = d;
        axi_req.wstrb = 4'($urandom());
        axi_req.awvalid = 1'b1;
        axi_req.wvalid = 1'b1;
        do @(posedge core_clk); while (!axi_rsp.awready && ++n < 50);
        #1;
        axi_req.awvalid = 1'b0;
        axi_req.wvalid = 1'b0;
        // Released lines show junk, not the old value
        axi_req.wdata = ~d;
        axi_req.awaddr = ~a;
        axi_req.bready = 1'b1;
        do @(posedge core_clk); while (!axi_rsp.bvalid && ++n < 50);
        r = (n < 50) ? axi_rsp.bresp : 2'h3;
        #1;
        axi_req.bready = 1'b0;
    endtask

    task automatic rd(input logic [12:0] a, output logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        #1;
        axi_req.araddr = a;
        axi_req.arvalid = 1'b1;
        do @(posedge core_clk); while (!axi_rsp.arready && ++n < 50);
        #1;
        axi_req.arvalid = 1'b0;
        axi_req.araddr = ~a;
        axi_req.rready = 1'b1;
        do @(posedge core_clk); while (!axi_rsp.rvalid && ++n < 50);
        d = axi_rsp.rdata;
        #1;
        axi_req.rready = 1'b0;
    endtask
endmodule

// File: test/testbench.sv
// Purpose: Self-checking bench for the serial port front end
// Assumes: Host model drives the register bus
// Notes: Read results are checked against a queue of notes
`include "ua_consts.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ua_pkg::*;

    typedef struct packed {
        logic [31:0] data;
        logic [31:0] mask;
        logic [1:0] resp;
    } ua_note_t;

    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    ua_axi_req_t axi_req;
    ua_axi_rsp_t axi_rsp;
    logic [7:0] rx_char_data = 8'h00;
    logic rx_char_valid = 1'b0;
    logic [3:0] rx_line_err = 4'h0;
    logic tx_char_ready = 1'b0;
    logic ring_indicate_n = 1'b1;
    logic rx_char_ready, tx_char_valid, terminal_ready_n, request_to_send_n;
    logic user_output_a_low, user_output_b_low, driver_disable;
    logic dma_rx_ready_n, dma_tx_ready_n, interrupt_out;
    logic [7:0] tx_char_data;
    logic [15:0] baud_divisor;
    int failures = 0;
    int compares = 0;
    ua_note_t notes[$];
    ua_note_t head;
    logic [1:0] resp;
    logic [31:0] dummy;
    logic [31:0] v;
    logic [7:0] chars[8];

    always #5 core_clk = ~core_clk;

    ua_host_model i_ua_host_model (.core_clk(core_clk), .axi_req(axi_req), .axi_rsp(axi_rsp));

    ua_front_end #(.FIFO_DEPTH(8)) i_ua_front_end (
        .core_clk(core_clk), .rst_b(rst_b), .axi_req(axi_req), .axi_rsp(axi_rsp),
        .rx_char_data(rx_char_data), .rx_char_valid(rx_char_valid),
        .rx_char_ready(rx_char_ready), .rx_line_err(rx_line_err),
        .tx_char_data(tx_char_data), .tx_char_valid(tx_char_valid),
        .tx_char_ready(tx_char_ready), .clear_to_send_n(1'b1), .data_set_ready_n(1'b1),
        .ring_indicate_n(ring_indicate_n), .carrier_detect_n(1'b1),
        .terminal_ready_n(terminal_ready_n), .request_to_send_n(request_to_send_n),
        .user_output_a_low(user_output_a_low), .user_output_b_low(user_output_b_low),
        .driver_disable(driver_disable), .dma_rx_ready_n(dma_rx_ready_n),
        .dma_tx_ready_n(dma_tx_ready_n), .interrupt_out(interrupt_out),
        .baud_divisor(baud_divisor)
    );

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic end_of_test();
        chk("pending notes", 32'h0, 32'(notes.size()));
        $display("Checks %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic wr(input logic [12:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
        i_ua_host_model.wr(a, d, resp);
        chk("write response", {30'h0, r}, {30'h0, resp});
    endtask

    task automatic rd(input logic [12:0] a, input logic [31:0] d,
                      input logic [31:0] m = 32'hffffffff, input logic [1:0] r = 2'h0);
        notes.push_back('{d & m, m, r});
        i_ua_host_model.rd(a, dummy);
    endtask

    task automatic push(input logic [7:0] c);
        rx_char_data = c;
        rx_char_valid = 1'b1;
        @(posedge core_clk);
        #1;
        rx_char_valid = 1'b0;
        rx_char_data = ~c;
        @(posedge core_clk);
        #1;
    endtask

    task automatic tick();
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    // Watcher: every read result takes the oldest note
    always @(posedge core_clk)
    begin
        if (rst_b && axi_rsp.rvalid === 1'b1 && axi_req.rready === 1'b1)
        begin
            head = notes.pop_front();
            chk("read data", head.data, axi_rsp.rdata & head.mask);
            chk("read response", {30'h0, head.resp}, {30'h0, axi_rsp.rresp});
        end
    end

    initial
    begin
        #100000;
        failures++;
        $display("[ERR] watchdog expected done seen hang");
        end_of_test();
    end

    initial
    begin
        void'($urandom(54144));
        repeat (4) @(posedge core_clk);
        #1;
        rst_b = 1'b1;
        chk("modem pins", 32'hf, {28'h0, terminal_ready_n, request_to_send_n,
            user_output_a_low, user_output_b_low});
        chk("misc pins", 32'hc, {28'h0, driver_disable, dma_rx_ready_n,
            dma_tx_ready_n, interrupt_out});
        chk("holding", 32'hff, {24'h0, tx_char_data});
        rd(`UA_OFF_IEN, 32'h0);
        rd(`UA_OFF_DATA, 32'h0);
        wr(`UA_OFF_IID, 32'h1);
        wr(`UA_OFF_IEN, 32'hfffffff5);
        rd(`UA_OFF_IEN, 32'h5);
        rd(`UA_OFF_IID, 32'hc1);
        wr(`UA_OFF_MCTL, 32'hf);
        tick();
        chk("modem pins", 32'h0, {28'h0, terminal_ready_n, request_to_send_n,
            user_output_a_low, user_output_b_low});
        rd(`UA_OFF_MCTL, 32'hf);
        wr(`UA_OFF_MCTL, 32'h0);
        tick();
        chk("modem pins", 32'hf, {28'h0, terminal_ready_n, request_to_send_n,
            user_output_a_low, user_output_b_low});
        // Divisor bank, junk in the upper bits
        v = $urandom();
        wr(`UA_OFF_LCTL, 32'h80);
        wr(`UA_OFF_DATA, v);
        wr(`UA_OFF_IEN, v >> 8);
        tick();
        chk("divisor", {16'h0, v[15:0]}, {16'h0, baud_divisor});
        rd(`UA_OFF_DATA, {24'h0, v[7:0]});
        rd(`UA_OFF_IEN, {24'h0, v[15:8]});
        rd(`UA_OFF_IID, 32'h1);
        rd(`UA_OFF_LCTL, 32'h80);
        wr(`UA_OFF_LCTL, 32'h3);
        rd(`UA_OFF_IEN, 32'h5);
        v = $urandom();
        wr(`UA_OFF_SCR, v);
        rd(`UA_OFF_SCR, {24'h0, v[7:0]});
        wr(13'h1020, v, `UA_RESP_SLVERR);
        rd(13'h1020, 32'h0, 32'hffffffff, `UA_RESP_SLVERR);
        v = $urandom();
        wr(`UA_OFF_DATA, v);
        chk("tx", {22'h0, 2'b11, v[7:0]},
            {22'h0, tx_char_valid, dma_tx_ready_n, tx_char_data});
        tx_char_ready = 1'b1;
        @(posedge core_clk);
        #1;
        tx_char_ready = 1'b0;
        chk("tx valid", 32'h0, {30'h0, tx_char_valid, dma_tx_ready_n});
        // Fill the buffer until it refuses
        for (int i = 0; i < 8; i++)
        begin
            chars[i] = 8'($urandom());
            push(chars[i]);
        end
        chk("rx ready", 32'h0, {30'h0, rx_char_ready, dma_rx_ready_n});
        push(8'h5a);
        chk("irq", 32'h1, {31'h0, interrupt_out});
        rx_line_err = 4'h1;
        @(posedge core_clk);
        #1;
        rx_line_err = 4'h0;
        tick();
        rd(`UA_OFF_IID, 32'hc6);
        rd(`UA_OFF_LSTS, 32'h3, 32'h1f);
        rd(`UA_OFF_IID, 32'hc4);
        for (int i = 0; i < 8; i++)
            rd(`UA_OFF_DATA, {24'h0, chars[i]});
        rd(`UA_OFF_DATA, 32'h0);
        rd(`UA_OFF_IID, 32'hc1);
        tick();
        chk("irq", 32'h2, {30'h0, dma_rx_ready_n, interrupt_out});
        wr(`UA_OFF_IEN, 32'h2);
        rd(`UA_OFF_IID, 32'hc2);
        chk("irq", 32'h1, {31'h0, interrupt_out});
        wr(`UA_OFF_IEN, 32'h8);
        tick();
        chk("irq", 32'h0, {31'h0, interrupt_out});
        ring_indicate_n = 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
        rd(`UA_OFF_MSTS, 32'h40, 32'hf0);
        // Ring ending is the edge that raises a modem delta
        ring_indicate_n = 1'b1;
        repeat (5) @(posedge core_clk);
        #1;
        chk("irq", 32'h1, {31'h0, interrupt_out});
        rd(`UA_OFF_IID, 32'hc0);
        rd(`UA_OFF_MSTS, 32'h04);
        tick();
        chk("irq", 32'h0, {31'h0, interrupt_out});
        end_of_test();
    end
endmodule
